// ===== hdl/dpw_pkg.sv
// package: constants and carrier types for the dual pot wiper command logic
package dpw_pkg;
    // data and array sizes
    localparam int DATA_W = 8;
    localparam int NUM_POTS = 2;
    localparam int NUM_SLOTS = 4;
    localparam int NUM_TAPS = 256;
    // instruction byte field positions
    localparam int OP_LSB = 4;
    localparam int SLOT_LSB = 2;
    localparam int IGNORE_BIT = 1;
    localparam int POT_BIT = 0;
    // first byte field positions
    localparam int TYPE_LSB = 4;
    localparam int STRAP_LSB = 0;
    // opcodes, upper nibble of the instruction byte
    localparam logic [3:0] OP_RD_WIPER = 4'h9;
    localparam logic [3:0] OP_WR_WIPER = 4'hA;
    localparam logic [3:0] OP_RD_SLOT = 4'hB;
    localparam logic [3:0] OP_WR_SLOT = 4'hC;
    localparam logic [3:0] OP_XS2W = 4'hD;
    localparam logic [3:0] OP_XW2S = 4'hE;
    localparam logic [3:0] OP_GS2W = 4'h1;
    localparam logic [3:0] OP_GW2S = 4'h8;
    localparam logic [3:0] OP_INCDEC = 4'h2;
    // bit engine positions
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [1:0] BYTE_ID = 2'h0;
    localparam logic [1:0] BYTE_INSTR = 2'h1;
    localparam logic [1:0] BYTE_DATA = 2'h2;
    localparam logic [1:0] BYTE_DONE = 2'h3;
    // reset and limit values
    localparam logic [7:0] SLOT_RESET = 8'h80;
    localparam logic [7:0] WIPER_TOP = 8'hFF;
    localparam logic [7:0] WIPER_BOTTOM = 8'h00;
    localparam logic [255:0] TAP_ONE = 256'h1;
    // arbitrary type code, not any real part's
    localparam logic [3:0] TYPE_CODE_DEF = 4'hA;
    // nonvolatile write time, longest, rounded down
    localparam int SYS_CLK_HZ = 20_000_000;
    localparam int NV_WRITE_US = 10_000;
    localparam int NV_CYCLES_DEF = NV_WRITE_US * (SYS_CLK_HZ / 1_000_000);
    // command handed from the link to the register side
    typedef struct packed {
        logic [3:0] op;
        logic [1:0] slot;
        logic pot;
        logic [7:0] data;
    } dpw_cmd_t;
endpackage

// ===== hdl/dpw_sync.sv
// three-stage synchroniser that passes a bit once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module dpw_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_reg; // metastable stage, read by s2 only
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg;
    // shift chain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // per bit, accept only a settled value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= '0;
        end else begin
            q_reg <= (s2_reg & s3_reg) | (q_reg & (s2_reg | s3_reg));
        end
    end
    assign q = q_reg;
endmodule
`default_nettype wire

// ===== hdl/dpw_core.sv
// dual pot wiper command logic: link bit engine, registers and tap decode
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - per pot 8-bit wiper, one-hot tap
// - write-wiper loads data byte into wiper
// - slot-to-wiper copies chosen slot in parallel
// - step instruction moves wiper one count
// - after reset wipers load from slot zero
// - wiper is volatile, reloaded each power-up
// - four 8-bit slots per pot, readable, writable
// - slot changes take nonvolatile write time
// - all eight slot bits are plain data
// - reads and writes use three bytes
// - transfers use two bytes then stop
// - global transfers act on both pots
// - wiper-to-slot runs a nonvolatile cycle
// - slot-to-wiper loads wiper at once
// - step with data high moves wiper up
// - step with data low moves wiper down
// - answer only on type and strap match
// - opcode high nibble, slot bits, pot bit
// - no acknowledge while nonvolatile write runs
module dpw_core #(
    parameter int NV_CYCLES = dpw_pkg::NV_CYCLES_DEF,
    parameter logic [3:0] TYPE_CODE = dpw_pkg::TYPE_CODE_DEF
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_clk,
    input wire logic link_frame,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [3:0] address_straps,
    output logic nv_busy,
    output logic [1:0][255:0] tap_select
);
    localparam int NV_CNT_W = $clog2(NV_CYCLES + 1);

    // register side storage
    logic [7:0] wiper_position_reg [2]; // volatile wipers
    logic [7:0] stored_setting_slot_reg [2][4]; // slot model
    logic init_done_reg; // low for the power-up load cycle
    logic nv_busy_reg;
    logic [NV_CNT_W-1:0] nv_cnt_reg;
    logic [1:0] pend_mask_reg; // pots with a slot write pending
    logic [1:0] pend_slot_reg;
    logic [7:0] pend_data_reg [2];
    logic step_pot_reg; // pot picked by the step instruction
    logic [1:0][255:0] tap_select_reg;
    logic [3:0] sys_prev_reg; // last settled link flags

    // link side state, clocked by scl
    logic link_rst_n; // bit state clears between frames
    logic [3:0] bit_cnt_reg; // 0..7 data bits, 8 = ack slot
    logic [1:0] byte_cnt_reg; // saturates at done
    logic [7:0] shift_reg;
    logic [7:0] instr_reg;
    logic addressed_reg;
    logic incdec_reg; // step phase of the frame
    dpw_pkg::dpw_cmd_t cmd_reg; // held stable for the other side
    logic cmd_tgl_reg;
    logic up_tgl_reg;
    logic dn_tgl_reg;
    logic sda_oe_reg;
    logic sda_out_reg;

    // crossing results
    logic [3:0] sys_q; // frame, down, up, command
    logic [4:0] link_q; // busy, straps

    // decode helpers
    logic busy_l;
    logic [3:0] straps_l;
    logic [3:0] op_s; // opcode in the shifter
    logic [3:0] op_l; // opcode latched
    logic id_match;
    logic xfer_s;
    logic write_l;
    logic read_l;
    logic ack_now;
    logic [7:0] rd_byte;
    logic cmd_evt;
    logic up_evt;
    logic dn_evt;
    logic stop_evt;
    logic [7:0] step_w; // wiper under stepping
    logic [7:0] xfer_src; // slot picked by the command

    // frame low holds the bit engine in reset
    assign link_rst_n = rst_n & link_frame;

    // level crossings into the link side; only edges inside a frame
    dpw_sync #(
        .W(5)
    ) u_link_sync (
        .clk(scl_clk),
        .rst_n(rst_n),
        .d({nv_busy_reg, address_straps}),
        .q(link_q)
    );

    // toggles and frame level into the register side
    dpw_sync #(
        .W(4)
    ) u_sys_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .d({link_frame, dn_tgl_reg, up_tgl_reg, cmd_tgl_reg}),
        .q(sys_q)
    );

    assign busy_l = link_q[4];
    assign straps_l = link_q[3:0];
    assign op_s = shift_reg[dpw_pkg::OP_LSB +: 4];
    assign op_l = instr_reg[dpw_pkg::OP_LSB +: 4];

    // first byte check
    assign id_match = (shift_reg[dpw_pkg::TYPE_LSB +: 4] == TYPE_CODE)
        && (shift_reg[dpw_pkg::STRAP_LSB +: 4] == straps_l);

    // two-byte instructions
    assign xfer_s = (op_s == dpw_pkg::OP_XS2W) || (op_s == dpw_pkg::OP_XW2S)
        || (op_s == dpw_pkg::OP_GS2W) || (op_s == dpw_pkg::OP_GW2S);

    // three-byte instructions
    assign write_l = (op_l == dpw_pkg::OP_WR_WIPER) || (op_l == dpw_pkg::OP_WR_SLOT);
    assign read_l = (op_l == dpw_pkg::OP_RD_WIPER) || (op_l == dpw_pkg::OP_RD_SLOT);

    // acknowledge per byte; busy hides the device
    always_comb begin
        ack_now = 1'b0;
        if (byte_cnt_reg == dpw_pkg::BYTE_ID) begin
            ack_now = id_match && !busy_l;
        end else if (byte_cnt_reg == dpw_pkg::BYTE_INSTR) begin
            ack_now = addressed_reg;
        end else if (byte_cnt_reg == dpw_pkg::BYTE_DATA) begin
            ack_now = addressed_reg && write_l;
        end
    end

    // read source; registers stay quiet while a read byte shifts out,
    // so the other domain's value is stable here
    always_comb begin
        if (op_l == dpw_pkg::OP_RD_WIPER) begin
            rd_byte = wiper_position_reg[instr_reg[dpw_pkg::POT_BIT]];
        end else begin
            rd_byte = stored_setting_slot_reg[instr_reg[dpw_pkg::POT_BIT]]
                [instr_reg[dpw_pkg::SLOT_LSB +: 2]];
        end
    end

    // bit and byte counting, data sampled on scl rise
    always_ff @(posedge scl_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_reg <= '0;
            byte_cnt_reg <= '0;
            shift_reg <= '0;
        end else if (!incdec_reg) begin
            if (bit_cnt_reg == dpw_pkg::ACK_SLOT) begin
                bit_cnt_reg <= '0;
                if (byte_cnt_reg != dpw_pkg::BYTE_DONE) begin
                    byte_cnt_reg <= byte_cnt_reg + 2'h1;
                end
            end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                shift_reg <= {shift_reg[6:0], sda_in};
            end
        end
    end

    // address match and instruction capture at the ack clock
    always_ff @(posedge scl_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            addressed_reg <= 1'b0;
            instr_reg <= '0;
            incdec_reg <= 1'b0;
        end else if (bit_cnt_reg == dpw_pkg::ACK_SLOT) begin
            if (byte_cnt_reg == dpw_pkg::BYTE_ID) begin
                addressed_reg <= id_match && !busy_l;
            end else if (byte_cnt_reg == dpw_pkg::BYTE_INSTR && addressed_reg) begin
                instr_reg <= shift_reg;
                instr_reg[dpw_pkg::IGNORE_BIT] <= 1'b0;
                incdec_reg <= (op_s == dpw_pkg::OP_INCDEC);
            end
        end
    end

    // command hand-off and step toggles; kept over frame ends
    // so that a toggle is never undone by the frame reset
    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= '0;
            cmd_tgl_reg <= 1'b0;
            up_tgl_reg <= 1'b0;
            dn_tgl_reg <= 1'b0;
        end else if (incdec_reg) begin
            if (sda_in) begin
                up_tgl_reg <= ~up_tgl_reg;
            end else begin
                dn_tgl_reg <= ~dn_tgl_reg;
            end
        end else if (addressed_reg && bit_cnt_reg == dpw_pkg::ACK_SLOT) begin
            if (byte_cnt_reg == dpw_pkg::BYTE_INSTR
                && (xfer_s || op_s == dpw_pkg::OP_INCDEC)) begin
                // transfers act on the instruction byte alone
                cmd_reg <= {op_s, shift_reg[dpw_pkg::SLOT_LSB +: 2],
                    shift_reg[dpw_pkg::POT_BIT], 8'h00};
                cmd_tgl_reg <= ~cmd_tgl_reg;
            end else if (byte_cnt_reg == dpw_pkg::BYTE_DATA && write_l) begin
                // writes carry the third byte
                cmd_reg <= {op_l, instr_reg[dpw_pkg::SLOT_LSB +: 2],
                    instr_reg[dpw_pkg::POT_BIT], shift_reg};
                cmd_tgl_reg <= ~cmd_tgl_reg;
            end
        end
    end

    // data line driven on scl fall; low for ack and for zero bits
    always_ff @(negedge scl_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sda_oe_reg <= 1'b0;
        end else if (bit_cnt_reg == dpw_pkg::ACK_SLOT) begin
            sda_oe_reg <= ack_now;
        end else if (byte_cnt_reg == dpw_pkg::BYTE_DATA && addressed_reg && read_l) begin
            sda_oe_reg <= ~rd_byte[3'h7 - bit_cnt_reg[2:0]];
        end else begin
            sda_oe_reg <= 1'b0;
        end
    end

    // open drain: the driven level is always low
    always_ff @(negedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out_reg <= 1'b0;
        end else begin
            sda_out_reg <= 1'b0;
        end
    end

    // event detection on settled crossings
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_prev_reg <= '0;
        end else begin
            sys_prev_reg <= sys_q;
        end
    end

    assign cmd_evt = sys_q[0] ^ sys_prev_reg[0];
    assign up_evt = sys_q[1] ^ sys_prev_reg[1];
    assign dn_evt = sys_q[2] ^ sys_prev_reg[2];
    assign stop_evt = sys_prev_reg[3] && !sys_q[3];
    assign step_w = wiper_position_reg[step_pot_reg];
    assign xfer_src = stored_setting_slot_reg[cmd_reg.pot][cmd_reg.slot];

    // first clock after reset is the power-up recall
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            init_done_reg <= 1'b0;
        end else begin
            init_done_reg <= 1'b1;
        end
    end

    // wiper registers: recall, command, then single steps
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wiper_position_reg <= '{default: dpw_pkg::WIPER_BOTTOM};
        end else if (!init_done_reg) begin
            for (int p = 0; p < dpw_pkg::NUM_POTS; p++) begin
                wiper_position_reg[p] <= stored_setting_slot_reg[p][0];
            end
        end else if (cmd_evt) begin
            case (cmd_reg.op)
                dpw_pkg::OP_WR_WIPER: begin
                    wiper_position_reg[cmd_reg.pot] <= cmd_reg.data;
                end
                dpw_pkg::OP_XS2W: begin
                    wiper_position_reg[cmd_reg.pot] <= xfer_src;
                end
                dpw_pkg::OP_GS2W: begin
                    for (int p = 0; p < dpw_pkg::NUM_POTS; p++) begin
                        wiper_position_reg[p] <= stored_setting_slot_reg[p][cmd_reg.slot];
                    end
                end
                default: begin
                    // unknown or other opcodes leave wipers alone
                end
            endcase
        end else if (up_evt && !dn_evt) begin
            if (step_w != dpw_pkg::WIPER_TOP) begin
                wiper_position_reg[step_pot_reg] <= step_w + 8'h01;
            end
        end else if (dn_evt && !up_evt) begin
            if (step_w != dpw_pkg::WIPER_BOTTOM) begin
                wiper_position_reg[step_pot_reg] <= step_w - 8'h01;
            end
        end
    end

    // pot picked for stepping
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            step_pot_reg <= 1'b0;
        end else if (cmd_evt && cmd_reg.op == dpw_pkg::OP_INCDEC) begin
            step_pot_reg <= cmd_reg.pot;
        end
    end

    // slot writes wait for the stop before the cycle starts
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_mask_reg <= '0;
            pend_slot_reg <= '0;
            pend_data_reg <= '{default: 8'h00};
        end else if (stop_evt) begin
            pend_mask_reg <= '0;
        end else if (cmd_evt) begin
            pend_slot_reg <= cmd_reg.slot;
            case (cmd_reg.op)
                dpw_pkg::OP_WR_SLOT: begin
                    pend_mask_reg <= 2'h1 << cmd_reg.pot;
                    pend_data_reg[cmd_reg.pot] <= cmd_reg.data;
                end
                dpw_pkg::OP_XW2S: begin
                    pend_mask_reg <= 2'h1 << cmd_reg.pot;
                    pend_data_reg[cmd_reg.pot] <= wiper_position_reg[cmd_reg.pot];
                end
                dpw_pkg::OP_GW2S: begin
                    pend_mask_reg <= 2'h3;
                    pend_data_reg[0] <= wiper_position_reg[0];
                    pend_data_reg[1] <= wiper_position_reg[1];
                end
                default: begin
                    // no slot change for the rest
                end
            endcase
        end
    end

    // slot storage; a reset stands for a fresh part
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            stored_setting_slot_reg <= '{default: '{default: dpw_pkg::SLOT_RESET}};
        end else if (stop_evt && !nv_busy_reg) begin
            for (int p = 0; p < dpw_pkg::NUM_POTS; p++) begin
                if (pend_mask_reg[p]) begin
                    stored_setting_slot_reg[p][pend_slot_reg] <= pend_data_reg[p];
                end
            end
        end
    end

    // write cycle timer; the link stays deaf while it runs
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            nv_busy_reg <= 1'b0;
            nv_cnt_reg <= '0;
        end else if (stop_evt && !nv_busy_reg && pend_mask_reg != 2'h0) begin
            nv_busy_reg <= 1'b1;
            nv_cnt_reg <= NV_CNT_W'(NV_CYCLES - 1);
        end else if (nv_busy_reg) begin
            if (nv_cnt_reg == '0) begin
                nv_busy_reg <= 1'b0;
            end else begin
                nv_cnt_reg <= nv_cnt_reg - NV_CNT_W'(1);
            end
        end
    end

    // tap decode, one switch closed per pot
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tap_select_reg <= '0;
        end else begin
            for (int p = 0; p < dpw_pkg::NUM_POTS; p++) begin
                tap_select_reg[p] <= dpw_pkg::TAP_ONE << wiper_position_reg[p];
            end
        end
    end

    assign sda_out = sda_out_reg;
    assign sda_oe = sda_oe_reg;
    assign nv_busy = nv_busy_reg;
    assign tap_select = tap_select_reg;

    // named steps for the checks
    sequence s_step_up;
        init_done_reg && up_evt && !dn_evt && !cmd_evt;
    endsequence

    sequence s_step_dn;
        init_done_reg && dn_evt && !up_evt && !cmd_evt;
    endsequence

    sequence s_id_slot;
        bit_cnt_reg == dpw_pkg::ACK_SLOT && byte_cnt_reg == dpw_pkg::BYTE_ID;
    endsequence

    a_tap_onehot: assert property (@(posedge sys_clk) disable iff (!rst_n)
        init_done_reg |=> tap_select_reg[0] == (dpw_pkg::TAP_ONE << $past(wiper_position_reg[0])))
        else $error("tap decode does not follow wiper");

    a_write_wiper: assert property (@(posedge sys_clk) disable iff (!rst_n)
        init_done_reg && cmd_evt && cmd_reg.op == dpw_pkg::OP_WR_WIPER
        |=> wiper_position_reg[cmd_reg.pot] == $past(cmd_reg.data))
        else $error("write wiper data not loaded");

    a_xfer_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        init_done_reg && cmd_evt && cmd_reg.op == dpw_pkg::OP_XS2W
        |=> wiper_position_reg[cmd_reg.pot] == $past(xfer_src))
        else $error("slot to wiper transfer missing");

    a_step_up: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_step_up ##0 (step_w != dpw_pkg::WIPER_TOP) |=> step_w == $past(step_w) + 8'h01)
        else $error("increment not one count");

    a_step_floor: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_step_dn ##0 (step_w == dpw_pkg::WIPER_BOTTOM) |=> step_w == dpw_pkg::WIPER_BOTTOM)
        else $error("decrement wrapped below zero");

    a_power_recall: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !init_done_reg |=> wiper_position_reg[0] == $past(stored_setting_slot_reg[0][0])
        && wiper_position_reg[1] == $past(stored_setting_slot_reg[1][0]))
        else $error("power-up recall missed");

    a_nv_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stop_evt && !nv_busy_reg && pend_mask_reg != 2'h0 |=> nv_busy_reg ##1 nv_busy_reg)
        else $error("slot write did not start a cycle");

    a_nv_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        nv_busy_reg && nv_cnt_reg == '0 |=> !nv_busy_reg)
        else $error("write cycle overran");

    a_busy_no_ack: assert property (@(negedge scl_clk) disable iff (!link_rst_n)
        s_id_slot ##0 busy_l |=> !sda_oe_reg)
        else $error("acknowledged while busy");

    a_addr_ack: assert property (@(negedge scl_clk) disable iff (!link_rst_n)
        s_id_slot ##0 (id_match && !busy_l) |=> sda_oe_reg)
        else $error("matching address not acknowledged");

    a_step_toggle: assert property (@(posedge scl_clk) disable iff (!link_rst_n)
        incdec_reg && sda_in |=> up_tgl_reg != $past(up_tgl_reg))
        else $error("step up pulse lost");
endmodule
`default_nettype wire

// ===== testbench/dpw_master.sv
// 2-wire bus master model: link clock, frame and data line
`timescale 1ns/100ps
`default_nettype none
module dpw_master (
    output logic scl_clk,
    output logic link_frame,
    output logic sda_drv,
    input wire logic sda_line
);
    // clock stands low between frames, data left to the pull-up
    initial begin
        scl_clk = 1'b0;
        link_frame = 1'b0;
        sda_drv = 1'b1;
    end
    // data set while clock low, held over the high phase
    task automatic clk_bit(input logic b, output logic s);
        sda_drv = b;
        #31.0 scl_clk = 1'b1;
        s = sda_line;
        #62.5 scl_clk = 1'b0;
        #31.5;
    endtask
    // msb first, ninth clock released for the acknowledge
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(v[i], s);
        end
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
    // line released for eight clocks, then the master acknowledges
    task automatic get_byte(output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, v[i]);
        end
        clk_bit(1'b0, s);
    endtask
    // frame opens with data low
    task automatic start();
        sda_drv = 1'b0;
        link_frame = 1'b1;
        #62.5;
    endtask
    // frame closes, then data back to the pull-up
    task automatic stop();
        sda_drv = 1'b0;
        #31.0 link_frame = 1'b0;
        sda_drv = 1'b1;
        #62.5;
    endtask
endmodule
`default_nettype wire

// ===== testbench/dual_pot_wiper_command_logic_tb_top.sv
// bench top: random and corner commands over the 2-wire link
`timescale 1ns/100ps
`default_nettype none
module dual_pot_wiper_command_logic_tb_top;
    localparam logic [7:0] ID_BYTE = {dpw_pkg::TYPE_CODE_DEF, 4'h5};
    logic sys_clk, rst_n, scl_clk, link_frame, sda_drv, sda_line, sda_out, sda_oe, nv_busy;
    logic id_ack, a;
    logic [3:0] straps;
    logic [1:0][255:0] tap_select;
    logic [7:0] wip [2];
    logic [7:0] slot [2][4];
    logic [7:0] rd;
    logic [31:0] seed;
    logic [3:0] ops [9];
    int n_fail, total_checks;
    // open-drain data line with pull-up
    assign sda_line = sda_drv & ~sda_oe;
    dpw_core #(.NV_CYCLES(60)) dpw_core_inst (.sys_clk(sys_clk), .rst_n(rst_n),
        .scl_clk(scl_clk), .link_frame(link_frame), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .address_straps(straps), .nv_busy(nv_busy), .tap_select(tap_select));
    dpw_master dpw_master_inst (.scl_clk(scl_clk), .link_frame(link_frame),
        .sda_drv(sda_drv), .sda_line(sda_line));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // one tap, held at the ends
    function automatic logic [7:0] step(input logic [7:0] v, input logic up);
        if (up) return (v == 8'hff) ? v : v + 8'h01;
        return (v == 8'h00) ? v : v - 8'h01;
    endfunction
    task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic taps();
        for (int p = 0; p < 2; p++) check("tap", tap_select[p], dpw_pkg::TAP_ONE << wip[p]);
        check("sda_out", sda_out, 1'b0);
    endtask
    // one frame; model follows only when addressed
    task automatic cmd(input logic [3:0] op, input logic [2:0] s, input logic p, input logic [7:0] d);
        int n;
        dpw_master_inst.start();
        dpw_master_inst.put_byte(ID_BYTE, id_ack);
        if (id_ack === 1'b1) begin
            dpw_master_inst.put_byte({op, s, p}, a);
            if (op == dpw_pkg::OP_WR_WIPER || op == dpw_pkg::OP_WR_SLOT) dpw_master_inst.put_byte(d, a);
            if (op == dpw_pkg::OP_RD_WIPER || op == dpw_pkg::OP_RD_SLOT) begin
                dpw_master_inst.get_byte(rd);
                check("read", rd, (op == dpw_pkg::OP_RD_SLOT) ? slot[p][s[2:1]] : wip[p]);
            end
            case (op)
                dpw_pkg::OP_WR_WIPER: wip[p] = d;
                dpw_pkg::OP_WR_SLOT: slot[p][s[2:1]] = d;
                dpw_pkg::OP_XS2W: wip[p] = slot[p][s[2:1]];
                dpw_pkg::OP_XW2S: slot[p][s[2:1]] = wip[p];
                dpw_pkg::OP_GS2W: wip = '{slot[0][s[2:1]], slot[1][s[2:1]]};
                dpw_pkg::OP_GW2S: for (int i = 0; i < 2; i++) slot[i][s[2:1]] = wip[i];
                default: ;
            endcase
        end
        dpw_master_inst.stop();
        repeat (10) @(posedge sys_clk);
        taps();
        if (id_ack === 1'b1 && op inside {dpw_pkg::OP_WR_SLOT, dpw_pkg::OP_XW2S, dpw_pkg::OP_GW2S}) begin
            check("busy", nv_busy, 1'b1);
            dpw_master_inst.start();
            dpw_master_inst.put_byte(ID_BYTE, a);
            dpw_master_inst.stop();
            check("ack while busy", a, 1'b0);
            n = 0;
            while (nv_busy !== 1'b0 && n < 200) begin
                @(posedge sys_clk);
                n++;
            end
            if (n >= 200) begin
                n_fail++;
                wrap_up();
            end
            // once the cycle is over the device answers its address again
            dpw_master_inst.start();
            dpw_master_inst.put_byte(ID_BYTE, a);
            dpw_master_inst.stop();
            check("ack after write", a, 1'b1);
        end
    endtask
    // step frame, one pulse per direction bit
    task automatic steps(input logic p, input logic [7:0] dirs, input int n);
        dpw_master_inst.start();
        dpw_master_inst.put_byte(ID_BYTE, a);
        dpw_master_inst.put_byte({dpw_pkg::OP_INCDEC, 3'h0, p}, a);
        for (int i = 0; i < n; i++) begin
            dpw_master_inst.clk_bit(dirs[i], a);
            wip[p] = step(wip[p], dirs[i]);
        end
        dpw_master_inst.stop();
        repeat (10) @(posedge sys_clk);
        taps();
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    initial begin
        rst_n = 1'b0;
        straps = 4'h5;
        n_fail = 0;
        total_checks = 0;
        seed = 32'h6d56_f87e;
        ops = '{4'hA, 4'h9, 4'hC, 4'hB, 4'hD, 4'hE, 4'h8, 4'h1, 4'h3};
        wip = '{2{dpw_pkg::SLOT_RESET}};
        slot = '{2{'{4{dpw_pkg::SLOT_RESET}}}};
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        taps();
        // every opcode but step, plus unknown 3, with random slot, pot, data and ignored bit
        for (int k = 0; k < 27; k++) begin
            seed = lfsr(seed);
            cmd(ops[k % 9], seed[3:1], seed[0], seed[15:8]);
        end
        cmd(dpw_pkg::OP_WR_WIPER, 3'h0, 1'b0, 8'hfe);
        steps(1'b0, 8'h07, 5);
        cmd(dpw_pkg::OP_WR_WIPER, 3'h0, 1'b1, 8'h01);
        steps(1'b1, 8'h00, 3);
        @(posedge sys_clk);
        straps <= 4'h6;
        cmd(dpw_pkg::OP_WR_WIPER, 3'h0, 1'b1, 8'h55);
        check("foreign id", id_ack, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
